// *** hdl/cbe_params.svh ***
`ifndef CBE_PARAMS_SVH
`define CBE_PARAMS_SVH

// register map: the byte address on the wishbone bus is the register index times four
`define CBE_ENABLE_IDX 6'h27
`define CBE_ENABLE_ADDR 8'h9C
`define CBE_STATUS_IDX 6'h28
`define CBE_STATUS_ADDR 8'hA0
`define CBE_PERIOD_IDX 6'h29
`define CBE_PERIOD_ADDR 8'hA4
// field positions and reset values
`define CBE_CHAN_LSB 4
`define CBE_CHAN_MSB 7
`define CBE_BUF_EN_BIT 3
`define CBE_ENABLE_RST 8'h00
// timing: default sample period in clock cycles is period register + 1
`define CBE_PERIOD_RST 8'h07
// bit positions of the channels inside the applied channel vector
`define CBE_CHAN_X 0
`define CBE_CHAN_Y 1
`define CBE_CHAN_Z 2
`define CBE_CHAN_T 3

`endif

// *** hdl/cbe_pkg.sv ***
`default_nettype none
package cbe_pkg;
    // channel enable vector, bit 0 x, 1 y, 2 z, 3 temperature
    typedef logic [3:0] cbe_chan_t;
    // apply state of the sample-period tracker
    typedef enum logic [1:0] {
        CBE_IDLE = 2'b00,
        CBE_WAIT = 2'b01,
        CBE_APPLY = 2'b10
    } cbe_state_t;
endpackage
`default_nettype wire

// *** hdl/cbe_clock_gate.sv ***
`timescale 1ns/1ps
`default_nettype none
// latch-free clock gate: enable sampled on the falling edge, glitch-free and gate
module cbe_clock_gate (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // gate control
    input wire logic en,
    // gated clock
    output logic gclk
);
    // enable held stable while clk is high, so the and cannot glitch
    logic en_lo_r;

    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_lo_r <= 1'b0;
        end else begin
            en_lo_r <= en;
        end
    end

    assign gclk = clk & en_lo_r;
endmodule
`default_nettype wire

// *** hdl/cbe_enable_regs.sv ***
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "cbe_params.svh"
// Notes on behaviour
// [R1] bits 7..4 enable x, y, z, temperature
// [R2] valid selection applied to all downstream blocks
// [R3] buffer enable clear gates buffer clocks off
// [R4] buffer enable set runs buffer clock
// [R5] register at 0x27, resets to zero
// [R6] readback unchanged; applies at next sample period

// register map, byte addresses on the wishbone side (index times four):
//   enable register at index 0x27, status view at 0x28, period at 0x29
// software may write the enable register at any time; it reads back exactly
// what was written, but the downstream copy only moves at the edge where the
// sample period counter reaches its terminal count
// holding a change to a period edge keeps every consumer on one setting per
// sample, at the cost of up to one period of latency after the write
// an empty channel set is invalid: the channel copy keeps its old value while
// the buffer enable still follows, so software can stop the buffer alone
// the buffer clock is a gated copy of clk and the one output that is not a
// flop; the gate samples its enable on the falling edge so it cannot chop a pulse
module cbe_enable_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // applied settings toward the signal path and buffer
    output logic [3:0] chan_en_o,
    output logic buf_en_o,
    output logic sample_tick_o,
    // gated buffer clock
    output logic buf_clk_o
);
    // software-visible enable register
    logic [7:0] enable_r;
    // sample period length minus one, in clock cycles
    logic [7:0] period_r;
    // free running sample period counter
    logic [7:0] per_cnt_r;
    // settings in force downstream
    cbe_pkg::cbe_chan_t chan_act_r;
    logic buf_act_r;
    // a new setting waits for the period boundary
    cbe_pkg::cbe_state_t state_r;
    // registered read data, held until the next read
    logic [31:0] dat_r;
    // one-cycle acknowledge and error answers
    logic ack_r;
    logic err_r;
    // one-cycle pulse after each period boundary
    logic tick_r;
    // a new, not yet answered bus request
    logic req;
    // address decodes for the three mapped registers
    logic hit_en;
    logic hit_st;
    logic hit_per;
    // counter at its terminal count this cycle
    logic boundary;
    // the written channel set is non-empty
    logic sel_valid;
    // an enable write taken this cycle
    logic wr_en;
    // gated clock from the gate cell
    logic gclk;

    // a request is only seen once; ack drops in the following cycle
    assign req = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
    // full byte address compare; the low two bits must be zero as well
    assign hit_en = (wb_adr_i == `CBE_ENABLE_ADDR);
    assign hit_st = (wb_adr_i == `CBE_STATUS_ADDR);
    assign hit_per = (wb_adr_i == `CBE_PERIOD_ADDR);
    // a write without byte lane 0 is answered but changes nothing
    assign wr_en = req & wb_we_i & hit_en & wb_sel_i[0];
    // terminal count of the sample period counter
    assign boundary = (per_cnt_r == period_r);
    // an empty channel set is not a valid selection, keep the old one
    assign sel_valid = (enable_r[`CBE_CHAN_MSB:`CBE_CHAN_LSB] != 4'h0); // see [R2]

    // bus answer: ack on mapped address, err otherwise, one cycle after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            ack_r <= req & (hit_en | hit_st | hit_per);
            err_r <= req & ~(hit_en | hit_st | hit_per);
        end
    end

    // enable register write, byte lane 0 only
    // the upper lanes carry nothing, so a write with only them selected is a no-op
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_r <= `CBE_ENABLE_RST; // see [R5]
        end else if (wr_en) begin
            // the written byte is kept whole, low bits included
            enable_r <= wb_dat_i[7:0]; // see [R6]
        end
    end

    // period register write
    // a shorter period takes effect at once; the counter wraps if it is past it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            period_r <= `CBE_PERIOD_RST;
        end else if (req & wb_we_i & hit_per & wb_sel_i[0]) begin
            period_r <= wb_dat_i[7:0];
        end
    end

    // read mux, upper bits read zero
    // writes leave the read data alone so the last read stays visible
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dat_r <= 32'h0000_0000;
        end else if (req & ~wb_we_i) begin
            if (hit_en) begin
                dat_r <= {24'h00_0000, enable_r}; // see [R6]
            end else if (hit_st) begin
                // status: applied channels, applied buffer enable, tracker state
                dat_r <= {24'h00_0000, chan_act_r, buf_act_r, 1'b0, state_r};
            end else if (hit_per) begin
                dat_r <= {24'h00_0000, period_r};
            end else begin
                dat_r <= 32'h0000_0000;
            end
        end
    end

    // sample period counter; also wraps if the period shrinks below it
    // the tick is registered, so it trails the boundary by one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            per_cnt_r <= 8'h00;
            tick_r <= 1'b0;
        end else begin
            per_cnt_r <= (boundary || per_cnt_r > period_r) ? 8'h00 : per_cnt_r + 8'h01;
            tick_r <= boundary;
        end
    end

    // pending tracker: a write marks a change, the boundary applies it
    // the state is only for software to see; the apply itself keys off boundary
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= cbe_pkg::CBE_IDLE;
        end else begin
            case (state_r)
                cbe_pkg::CBE_IDLE: begin
                    // any taken enable write arms the tracker
                    if (wr_en) begin
                        state_r <= cbe_pkg::CBE_WAIT;
                    end
                end
                cbe_pkg::CBE_WAIT: begin
                    // the next terminal count applies it
                    if (boundary) begin
                        state_r <= cbe_pkg::CBE_APPLY;
                    end
                end
                cbe_pkg::CBE_APPLY: begin
                    // one cycle of apply, visible in the status view
                    state_r <= cbe_pkg::CBE_IDLE;
                end
                default: begin
                    state_r <= cbe_pkg::CBE_IDLE;
                end
            endcase
        end
    end

    // applied settings change only at a period boundary
    // holding them until then protects a sample already in flight
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_act_r <= 4'h0;
            buf_act_r <= 1'b0;
        end else if (boundary) begin
            if (sel_valid) begin
                chan_act_r <= enable_r[`CBE_CHAN_MSB:`CBE_CHAN_LSB]; // see [R1] see [R2] see [R6]
            end
            // the buffer enable loads even when the channel set is invalid
            buf_act_r <= enable_r[`CBE_BUF_EN_BIT]; // see [R6]
        end
    end

    // buffer clock gated by the applied enable
    // the gate cell is the only place the buffer clock is formed
    cbe_clock_gate u_gate (
        .clk(clk),
        .rst_n(rst_n),
        .en(buf_act_r), // see [R3] see [R4]
        .gclk(gclk)
    );

    // registered outputs, then the gated buffer clock from the gate cell
    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign wb_dat_o = dat_r;
    assign chan_en_o = chan_act_r; // see [R2]
    assign buf_en_o = buf_act_r;
    assign sample_tick_o = tick_r;
    // gated clock cannot come from a flip-flop without breaking it
    assign buf_clk_o = gclk;

    // assertions: checks on what this block drives
    // the buffer clock checks sample on the falling edge, where the gated clock
    // still shows whether the gate let the last rising edge through
    // reset is watched directly, so this one has no disable
    reset_clear_a: assert property (@(posedge clk) // see [R5]
        !rst_n |-> enable_r == `CBE_ENABLE_RST && chan_en_o == 4'h0 && !buf_en_o)
        else $error("enable state not cleared in reset");
    // a valid channel set reaches the outputs right after the boundary
    chan_apply_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R1]
        boundary && sel_valid |=> chan_en_o == $past(enable_r[`CBE_CHAN_MSB:`CBE_CHAN_LSB]))
        else $error("channel set not applied at boundary");
    // an empty channel set leaves the applied channels alone
    chan_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R2]
        boundary && !sel_valid |=> $stable(chan_en_o))
        else $error("invalid channel set applied");
    // channels never move between boundaries
    chan_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R2]
        !$past(boundary) |-> $stable(chan_en_o))
        else $error("channel set changed off boundary");
    // the buffer enable never moves between boundaries
    buf_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R6]
        !$past(boundary) |-> $stable(buf_en_o))
        else $error("buffer enable changed off boundary");
    // disabled buffer: no clock pulse once the gate has seen it
    buf_off_a: assert property (@(negedge clk) disable iff (!rst_n) // see [R3]
        !buf_en_o ##1 !buf_en_o |-> !buf_clk_o)
        else $error("buffer clock runs while disabled");
    // enabled buffer: every clock pulse passes once the gate has seen it
    buf_run_a: assert property (@(negedge clk) disable iff (!rst_n) // see [R4]
        buf_en_o ##1 buf_en_o |-> buf_clk_o)
        else $error("buffer clock stopped while enabled");
    // the buffer enable always loads at the boundary
    buf_apply_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R4]
        boundary |=> buf_en_o == $past(enable_r[`CBE_BUF_EN_BIT]))
        else $error("buffer enable not applied");
    // a read of the enable register returns the stored byte
    read_back_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R6]
        req & ~wb_we_i & hit_en |=> wb_ack_o && wb_dat_o[7:0] == $past(enable_r))
        else $error("readback mismatch");
    // a taken write lands whole
    write_land_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R6]
        wr_en |=> enable_r == $past(wb_dat_i[7:0]))
        else $error("enable write lost");
    // a write without byte lane 0 keeps the register
    lane_off_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R6]
        req && wb_we_i && hit_en && !wb_sel_i[0] |=> $stable(enable_r))
        else $error("write without lane 0 changed the register");
    // a refused access keeps the register
    err_no_write_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R6]
        req && !(hit_en || hit_st || hit_per) |=> $stable(enable_r))
        else $error("refused access changed the register");
    // acknowledge is a single cycle
    ack_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    // error is a single cycle
    err_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        wb_err_o |=> !wb_err_o)
        else $error("err held too long");
    // never both answers at once
    answer_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o |-> !wb_err_o)
        else $error("ack and err together");
    // unmapped addresses are refused with err
    unmapped_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        req & ~(hit_en | hit_st | hit_per) |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    // the unused upper read bits stay zero
    dat_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    // the tick follows every boundary
    tick_follow_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R6]
        boundary |=> sample_tick_o)
        else $error("tick missing after boundary");
    // and comes at no other time
    tick_only_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R6]
        !boundary |=> !sample_tick_o)
        else $error("tick without boundary");
    // a counter past a shrunk period wraps at once
    count_wrap_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R6]
        per_cnt_r > period_r |=> per_cnt_r == 8'h00)
        else $error("period counter did not wrap");
    // an enable write arms the tracker
    track_arm_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R6]
        state_r == cbe_pkg::CBE_IDLE && wr_en |=> state_r == cbe_pkg::CBE_WAIT)
        else $error("tracker not armed by write");
    // the boundary moves the tracker to apply
    track_apply_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R6]
        state_r == cbe_pkg::CBE_WAIT && boundary |=> state_r == cbe_pkg::CBE_APPLY)
        else $error("tracker missed the boundary");
    // apply lasts one cycle
    track_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == cbe_pkg::CBE_APPLY |=> state_r == cbe_pkg::CBE_IDLE)
        else $error("tracker stuck in apply");
    // main scenarios
    cover_write_c: cover property (@(posedge clk) wr_en);
    cover_apply_c: cover property (@(posedge clk) state_r == cbe_pkg::CBE_APPLY);
    cover_buf_c: cover property (@(posedge clk) $rose(buf_en_o));
    cover_err_c: cover property (@(posedge clk) wb_err_o);
    cover_invalid_c: cover property (@(posedge clk) boundary && !sel_valid);
endmodule
`default_nettype wire

// *** testbench/tb_channel_and_buffer_enable.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_channel_and_buffer_enable;
    // clock and reset, all inputs defined at time zero
    logic clk = 1'b0;
    // starts high so the drop at time zero is a real reset edge
    logic rst_n = 1'b1;
    // wishbone master side
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    // design outputs
    logic [31:0] rdat;
    logic ack, err, tick, ben, bclk;
    logic [3:0] chan;
    // last bus answer, counters
    logic [31:0] q;
    logic qerr;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int nb = 0;
    always #4 clk = ~clk;
    // rising edges of the gated buffer clock
    always @(posedge bclk) nb++;
    cbe_enable_regs u_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .chan_en_o(chan), .buf_en_o(ben),
        .sample_tick_o(tick), .buf_clk_o(bclk));
    // verdict, the only place the run ends
    task automatic conclude();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // compare one value, case equality so unknowns fail
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle; request held until ack or err is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do @(posedge clk); while (!(ack === 1'b1 || err === 1'b1));
        q = rdat;
        qerr = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // two ticks guarantee a whole period boundary after the last write
    task automatic wait_apply();
        repeat (2) begin
            do @(posedge clk); while (tick !== 1'b1);
        end
    endtask
    // count buffer clock edges over a short span
    task automatic buf_clk_runs(input int exp_min, input int exp_max);
        nb = 0;
        repeat (6) @(posedge clk);
        cmp(32'(nb >= exp_min && nb <= exp_max), 32'h1);
    endtask
    // everything starts disabled after reset
    task automatic t_reset();
        cmp(32'(chan), 32'h0);
        cmp(32'(ben), 32'h0);
        bus(1'b0, 8'h9C, 4'hF, 32'h0);
        cmp(q, 32'h0);
        buf_clk_runs(0, 0);
    endtask
    // all channels plus buffer; readback, then applied downstream
    task automatic t_all_on();
        bus(1'b1, 8'h9C, 4'hF, 32'h0000_00F8);
        bus(1'b0, 8'h9C, 4'hF, 32'h0);
        cmp(q, 32'h0000_00F8);
        wait_apply();
        cmp(32'(chan), 32'hF);
        cmp(32'(ben), 32'h1);
        buf_clk_runs(5, 6);
    endtask
    // each channel bit alone maps to its own output, buffer off
    task automatic t_channel_map();
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 8'h9C, 4'hF, 32'h10 << i);
            wait_apply();
            cmp(32'(chan), 32'h1 << i);
            cmp(32'(ben), 32'h0);
            buf_clk_runs(0, 0);
        end
    endtask
    // empty channel set is invalid: last channels kept, buffer still follows
    task automatic t_invalid_sel();
        bus(1'b1, 8'h9C, 4'hF, 32'h0000_0008);
        wait_apply();
        cmp(32'(chan), 32'h8);
        cmp(32'(ben), 32'h1);
    endtask
    // byte lane off and unmapped address leave the register alone
    task automatic t_refused();
        bus(1'b1, 8'h9C, 4'hE, 32'h0000_00F0);
        cmp(32'(qerr), 32'h0);
        bus(1'b1, 8'h00, 4'hF, 32'h0000_00FF);
        cmp(32'(qerr), 32'h1);
        bus(1'b0, 8'h9C, 4'hF, 32'h0);
        cmp(q, 32'h0000_0008);
    endtask
    // a write holds off until the next boundary; status, period and tick spacing
    task automatic t_period_status();
        int n;
        wait_apply();
        bus(1'b1, 8'h9C, 4'hF, 32'h0000_0038);
        cmp(32'(chan), 32'h8);
        wait_apply();
        cmp(32'(chan), 32'h3);
        bus(1'b0, 8'hA0, 4'hF, 32'h0);
        cmp(q, 32'h0000_0038);
        bus(1'b0, 8'hA4, 4'hF, 32'h0);
        cmp(q, 32'h0000_0007);
        bus(1'b1, 8'hA4, 4'hF, 32'h0000_0003);
        wait_apply();
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1);
        cmp(32'(n), 32'h4);
    endtask
    // reset in mid-run clears register and applied outputs
    task automatic t_mid_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        cmp(32'(chan), 32'h0);
        cmp(32'(ben), 32'h0);
        rst_n <= 1'b1;
        bus(1'b0, 8'h9C, 4'hF, 32'h0);
        cmp(q, 32'h0);
    endtask
    // hang guard: the whole run needs well under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            conclude();
        end
    end
    initial begin
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_all_on();
        t_channel_map();
        t_invalid_sel();
        t_refused();
        t_period_status();
        t_mid_reset();
        conclude();
    end
endmodule
`default_nettype wire
